// ---- inc/amc_pkg.sv ----
// package: constants and types for the operating-mode control block
package amc_pkg;

  // ==========================================================
  // register map
  localparam int unsigned AXI_AW        = 8;
  localparam logic [7:0]  OPCTL_IDX     = 8'h01;
  localparam logic [7:0]  OPCTL_ADDR    = 8'h04;   // index times four
  localparam logic [7:0]  STATUS_ADDR   = 8'h08;
  localparam logic [15:0] OPCTL_RST     = 16'h2000;
  localparam logic [15:0] OPCTL_WR_MASK = 16'hE77C; // bits that store writes

  // ==========================================================
  // field positions
  localparam int unsigned REF_EN_BIT    = 15;
  localparam int unsigned SETTLED_BIT   = 13;
  localparam int unsigned DELAY_LSB     = 8;
  localparam int unsigned MODE_LSB      = 4;
  localparam int unsigned CLKSEL_LSB    = 2;
  localparam int unsigned STAT_RDY_BIT  = 0;
  localparam int unsigned STAT_HOLD_BIT = 1;

  // ==========================================================
  // response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // settling times in ns, clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DLY1_NS       = 32000;
  localparam int unsigned DLY2_NS       = 128000;
  localparam int unsigned DLY3_NS       = 320000;
  localparam int unsigned DLY4_NS       = 800000;
  localparam int unsigned DLY5_NS       = 1600000;
  localparam int unsigned DLY6_NS       = 4000000;
  localparam int unsigned DLY7_NS       = 8000000;
  // least times, rounded up to whole cycles
  localparam int unsigned DLY1_CYC = (DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY2_CYC = (DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY3_CYC = (DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY4_CYC = (DLY4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY5_CYC = (DLY5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY6_CYC = (DLY6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY7_CYC = (DLY7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W   = 19;

  // ==========================================================
  // operating modes and clock sources
  typedef enum logic [2:0] {
    AMC_CONTINUOUS, AMC_SINGLE, AMC_STANDBY, AMC_POWER_DOWN,
    AMC_INT_OFFSET, AMC_INT_GAIN, AMC_SYS_OFFSET, AMC_SYS_GAIN
  } amc_mode_t;

  typedef enum logic [1:0] {
    AMC_CLK_INT, AMC_CLK_INT_OUT, AMC_CLK_EXT, AMC_CLK_XTAL
  } amc_clksel_t;

  // clock and reference controls that leave the block together
  typedef struct packed {
    logic ref_enable;
    logic osc_enable;
    logic clk_io_oe;
    logic ext_clk_sel;
    logic xtal_sel;
  } amc_analog_t;

endpackage : amc_pkg

// ---- core/amc_core.sv ----
// core: operating-mode control register with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - control register sits at index 0x01, resets to 0x2000.
// - each control write restarts the filter and clears conversion-ready, unless a conversion finishes in the same cycle.
// - each completed control write outside standby and power-down launches a conversion or calibration per mode.
// - bit 15 turns on the internal reference driving the reference output pin.
// - bit 13 with one channel gives settled-rate results only; resets set.
// - bits 10:8 pick settling delay 0 us up to 8 ms.
// - after a channel switch processing waits out the programmed delay.
// - bits 6:4 pick continuous, single, standby, power-down or four calibrations.
// - bits 3:2 pick internal, internal driven out, external clock or crystal.
// - any internal oscillator selection also powers the oscillator up.
module amc_core #(
  parameter int unsigned P_DLY1_CYC = amc_pkg::DLY1_CYC,
  parameter int unsigned P_DLY2_CYC = amc_pkg::DLY2_CYC,
  parameter int unsigned P_DLY3_CYC = amc_pkg::DLY3_CYC,
  parameter int unsigned P_DLY4_CYC = amc_pkg::DLY4_CYC,
  parameter int unsigned P_DLY5_CYC = amc_pkg::DLY5_CYC,
  parameter int unsigned P_DLY6_CYC = amc_pkg::DLY6_CYC,
  parameter int unsigned P_DLY7_CYC = amc_pkg::DLY7_CYC
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // axi4-lite write address and data
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [amc_pkg::AXI_AW-1:0]  i_awaddr,
  input  wire logic [2:0]                  i_awprot,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  // axi4-lite write response
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // axi4-lite read
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [amc_pkg::AXI_AW-1:0]  i_araddr,
  input  wire logic [2:0]                  i_arprot,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  // converter core events
  input  wire logic                        i_chan_switch,
  input  wire logic                        i_conv_done,
  input  wire logic                        i_single_chan,
  // converter controls
  output logic                             o_filter_restart,
  output logic                             o_start,
  output amc_pkg::amc_mode_t               o_mode,
  output logic                             o_conv_ready,
  output logic                             o_settle_hold,
  output logic                             o_settled_only,
  output amc_pkg::amc_analog_t             o_analog
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]                 ctrl;
    logic                        aw_ok;
    logic [amc_pkg::AXI_AW-1:0]  aw_addr;
    logic                        w_ok;
    logic [15:0]                 w_data;
    logic [1:0]                  w_strb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic                        flt_rst;
    logic                        start;
    logic                        conv_rdy;
    logic [amc_pkg::HOLD_W-1:0]  hold_cnt;
    logic                        hold;
    logic                        settled;
    amc_pkg::amc_analog_t        analog;
  } amc_state_t;

  amc_state_t st_ff;
  amc_state_t nxt_st;
  logic       wr_fire;
  logic       ar_fire;

  // settling count for a delay code
  function automatic logic [amc_pkg::HOLD_W-1:0] hold_cycles(input logic [2:0] code);
    logic [amc_pkg::HOLD_W-1:0] n;
    n = '0;
    unique case (code)
      3'h0: n = '0;
      3'h1: n = amc_pkg::HOLD_W'(P_DLY1_CYC);
      3'h2: n = amc_pkg::HOLD_W'(P_DLY2_CYC);
      3'h3: n = amc_pkg::HOLD_W'(P_DLY3_CYC);
      3'h4: n = amc_pkg::HOLD_W'(P_DLY4_CYC);
      3'h5: n = amc_pkg::HOLD_W'(P_DLY5_CYC);
      3'h6: n = amc_pkg::HOLD_W'(P_DLY6_CYC);
      3'h7: n = amc_pkg::HOLD_W'(P_DLY7_CYC);
    endcase
    return n;
  endfunction : hold_cycles

  // modes that start work after a write
  function automatic logic mode_launches(input logic [2:0] m);
    return !(m == amc_pkg::AMC_STANDBY || m == amc_pkg::AMC_POWER_DOWN);
  endfunction : mode_launches

  assign wr_fire = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
  assign ar_fire = i_arvalid && st_ff.arready;

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.flt_rst = 1'b0;
    nxt_st.start   = 1'b0;
    // capture address and data in either order
    if (i_awvalid && st_ff.awready)
    begin
      nxt_st.aw_ok   = 1'b1;
      nxt_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && st_ff.wready)
    begin
      nxt_st.w_ok   = 1'b1;
      nxt_st.w_data = i_wdata[15:0];
      nxt_st.w_strb = i_wstrb[1:0];
    end
    // write completes once both halves are held
    if (wr_fire)
    begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = amc_pkg::RESP_OKAY;
      if (st_ff.aw_addr[amc_pkg::AXI_AW-1:2] == amc_pkg::OPCTL_ADDR[amc_pkg::AXI_AW-1:2])
      begin
        // byte lanes, stored bits only
        if (st_ff.w_strb[0])
          nxt_st.ctrl[7:0] = st_ff.w_data[7:0] & amc_pkg::OPCTL_WR_MASK[7:0];
        if (st_ff.w_strb[1])
          nxt_st.ctrl[15:8] = st_ff.w_data[15:8] & amc_pkg::OPCTL_WR_MASK[15:8];
        nxt_st.flt_rst  = 1'b1;
        nxt_st.conv_rdy = 1'b0;
        nxt_st.start    = mode_launches(nxt_st.ctrl[amc_pkg::MODE_LSB +: 3]);
      end
      else if (st_ff.aw_addr[amc_pkg::AXI_AW-1:2] !=
               amc_pkg::STATUS_ADDR[amc_pkg::AXI_AW-1:2])
        nxt_st.bresp = amc_pkg::RESP_SLVERR;
    end
    if (st_ff.bvalid && i_bready)
      nxt_st.bvalid = 1'b0;
    // finished conversion wins over the clear
    if (i_conv_done)
      nxt_st.conv_rdy = 1'b1;
    // read path, one beat at a time
    if (ar_fire)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = amc_pkg::RESP_OKAY;
      nxt_st.rdata  = '0;
      if (i_araddr[amc_pkg::AXI_AW-1:2] == amc_pkg::OPCTL_ADDR[amc_pkg::AXI_AW-1:2])
        nxt_st.rdata[15:0] = st_ff.ctrl;
      else if (i_araddr[amc_pkg::AXI_AW-1:2] == amc_pkg::STATUS_ADDR[amc_pkg::AXI_AW-1:2])
      begin
        nxt_st.rdata[amc_pkg::STAT_RDY_BIT]  = st_ff.conv_rdy;
        nxt_st.rdata[amc_pkg::STAT_HOLD_BIT] = st_ff.hold;
      end
      else
        nxt_st.rresp = amc_pkg::RESP_SLVERR;
    end
    else if (st_ff.rvalid && i_rready)
      nxt_st.rvalid = 1'b0;
    // ready flags as registered outputs
    nxt_st.awready = !nxt_st.aw_ok && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_ok && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
    // post-switch settling count
    if (i_chan_switch)
    begin
      nxt_st.hold_cnt = hold_cycles(st_ff.ctrl[amc_pkg::DELAY_LSB +: 3]);
      nxt_st.hold     = (nxt_st.hold_cnt != '0);
    end
    else if (st_ff.hold_cnt != '0)
    begin
      nxt_st.hold_cnt = st_ff.hold_cnt - amc_pkg::HOLD_W'(1);
      nxt_st.hold     = (st_ff.hold_cnt != amc_pkg::HOLD_W'(1));
    end
    // derived controls follow the register
    nxt_st.settled = nxt_st.ctrl[amc_pkg::SETTLED_BIT] && i_single_chan;
    nxt_st.analog.ref_enable  = nxt_st.ctrl[amc_pkg::REF_EN_BIT];
    nxt_st.analog.osc_enable  = !nxt_st.ctrl[amc_pkg::CLKSEL_LSB + 1];
    nxt_st.analog.clk_io_oe   =
      (nxt_st.ctrl[amc_pkg::CLKSEL_LSB +: 2] == amc_pkg::AMC_CLK_INT_OUT);
    nxt_st.analog.ext_clk_sel =
      (nxt_st.ctrl[amc_pkg::CLKSEL_LSB +: 2] == amc_pkg::AMC_CLK_EXT);
    nxt_st.analog.xtal_sel    =
      (nxt_st.ctrl[amc_pkg::CLKSEL_LSB +: 2] == amc_pkg::AMC_CLK_XTAL);
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_ff         <= '0;
      st_ff.ctrl    <= amc_pkg::OPCTL_RST;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.analog  <= '{ref_enable: 1'b0, osc_enable: 1'b1, clk_io_oe: 1'b0,
                         ext_clk_sel: 1'b0, xtal_sel: 1'b0};
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // outputs straight from the state register
  assign o_awready        = st_ff.awready;
  assign o_wready         = st_ff.wready;
  assign o_bvalid         = st_ff.bvalid;
  assign o_bresp          = st_ff.bresp;
  assign o_arready        = st_ff.arready;
  assign o_rvalid         = st_ff.rvalid;
  assign o_rdata          = st_ff.rdata;
  assign o_rresp          = st_ff.rresp;
  assign o_filter_restart = st_ff.flt_rst;
  assign o_start          = st_ff.start;
  assign o_mode           = amc_pkg::amc_mode_t'(st_ff.ctrl[amc_pkg::MODE_LSB +: 3]);
  assign o_conv_ready     = st_ff.conv_rdy;
  assign o_settle_hold    = st_ff.hold;
  assign o_settled_only   = st_ff.settled;
  assign o_analog         = st_ff.analog;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_reset_value: assert property ($fell(i_sys_rst) |-> st_ff.ctrl == amc_pkg::OPCTL_RST)
    else $error("control register not at reset value");

  a_write_restarts: assert property (wr_fire && !i_conv_done &&
      st_ff.aw_addr[7:2] == 6'h01 |=> o_filter_restart && !o_conv_ready)
    else $error("control write did not restart filter");

  a_launch_pulse: assert property (wr_fire && st_ff.aw_addr[7:2] == 6'h01 &&
      nxt_st.ctrl[6:4] != 3'h2 && nxt_st.ctrl[6:4] != 3'h3
      |=> o_start && o_bvalid ##1 !o_start)
    else $error("launch pulse missing after control write");

  a_ref_enable: assert property (o_analog.ref_enable == st_ff.ctrl[15])
    else $error("reference enable disagrees with bit 15");

  a_settled_only: assert property (##1 o_settled_only ==
      (st_ff.ctrl[13] && $past(i_single_chan)))
    else $error("settled-only output wrong");

  a_no_delay: assert property (i_chan_switch && st_ff.ctrl[10:8] == 3'h0
      |=> !o_settle_hold)
    else $error("hold raised with zero delay");

  a_hold_span: assert property (i_chan_switch && st_ff.ctrl[10:8] != 3'h0
      |=> o_settle_hold [*8])
    else $error("settling hold ended early");

  a_start_mode: assert property (o_start |-> o_mode != 3'h2 && o_mode != 3'h3)
    else $error("launch in standby or power-down");

  a_clk_out: assert property (o_analog.clk_io_oe == (st_ff.ctrl[3:2] == 2'b01))
    else $error("clock pin drive wrong");

  a_osc_on: assert property (st_ff.ctrl[3] == 1'b0 |-> o_analog.osc_enable)
    else $error("oscillator off while selected");

  a_reserved_zero: assert property (st_ff.ctrl[12:11] == 2'b00 &&
      st_ff.ctrl[7] == 1'b0 && st_ff.ctrl[1:0] == 2'b00)
    else $error("read-only reserved bit set");

  a_ready_wins: assert property (i_conv_done |=> o_conv_ready)
    else $error("conversion-ready lost");

endmodule : amc_core

// ---- tb/amc_host_model.sv ----
// host model: register-bus master for the control block
`timescale 1ns/1ps
module amc_host_model (
  // clock
  input  wire logic        i_clk,
  // write channels
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [7:0]       o_awaddr,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  input  wire logic [1:0]  i_bresp,
  // read channels
  output logic             o_arvalid,
  input  wire logic        i_arready,
  output logic [7:0]       o_araddr,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  // idle bus from time zero; continuous readback is never enabled here
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
    {o_awaddr, o_wdata, o_wstrb, o_araddr} = '0;
  end

  // one write; released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit raw,
                    output logic [1:0] resp);
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_awaddr  <= a;
    o_wdata   <= raw ? d : (d & 32'h0000_E77C);
    o_wstrb   <= 4'hF;
    o_bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (i_awready && o_awvalid) {o_awvalid, o_awaddr} <= {1'b0, ~o_awaddr};
      if (i_wready && o_wvalid) {o_wvalid, o_wdata} <= {1'b0, ~o_wdata};
    end while (!(i_bvalid && o_bready));
    resp = i_bresp;
    o_bready <= 1'b0;
  endtask : wr

  // one read; data is judged by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (i_arready && o_arvalid) {o_arvalid, o_araddr} <= {1'b0, ~o_araddr};
    end while (!(i_rvalid && o_rready));
    o_rready <= 1'b0;
  endtask : rd
endmodule : amc_host_model

// ---- tb/adc_mode_control_tb_top.sv ----
// self-checking bench for the operating-mode control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module adc_mode_control_tb_top;
  // short hold counts, each nonzero one long enough for the eight-cycle hold check
  localparam int N_CYC [8] = '{0, 9, 10, 11, 12, 13, 14, 15};
  logic                  i_clk, i_sys_rst, chan_sw, conv_dn, single;
  logic                  aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic                  ar_valid, ar_ready, r_valid, r_ready;
  logic [7:0]            aw_addr, ar_addr;
  logic [31:0]           w_data, r_data;
  logic [3:0]            w_strb;
  logic [1:0]            b_resp, r_resp, resp;
  logic                  filt_rst, start, conv_rdy, hold, settled;
  amc_pkg::amc_mode_t    mode;
  amc_pkg::amc_analog_t  analog;
  logic [15:0]           v;
  logic [31:0]           seed;
  logic [34:0]           e;
  logic [34:0]           exp_q [$];
  int                    num_errors, n_tests, n_rst, n_st, r0, s0, cnt;

  amc_core #(.P_DLY1_CYC(N_CYC[1]), .P_DLY2_CYC(N_CYC[2]), .P_DLY3_CYC(N_CYC[3]),
    .P_DLY4_CYC(N_CYC[4]), .P_DLY5_CYC(N_CYC[5]), .P_DLY6_CYC(N_CYC[6]),
    .P_DLY7_CYC(N_CYC[7])) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_awvalid(aw_valid), .o_awready(aw_ready), .i_awaddr(aw_addr), .i_awprot(3'h0),
    .i_wvalid(w_valid), .o_wready(w_ready), .i_wdata(w_data), .i_wstrb(w_strb),
    .o_bvalid(b_valid), .i_bready(b_ready), .o_bresp(b_resp),
    .i_arvalid(ar_valid), .o_arready(ar_ready), .i_araddr(ar_addr), .i_arprot(3'h0),
    .o_rvalid(r_valid), .i_rready(r_ready), .o_rdata(r_data), .o_rresp(r_resp),
    .i_chan_switch(chan_sw), .i_conv_done(conv_dn), .i_single_chan(single),
    .o_filter_restart(filt_rst), .o_start(start), .o_mode(mode), .o_conv_ready(conv_rdy),
    .o_settle_hold(hold), .o_settled_only(settled), .o_analog(analog));

  amc_host_model HOST (.i_clk(i_clk), .o_awvalid(aw_valid), .i_awready(aw_ready),
    .o_awaddr(aw_addr), .o_wvalid(w_valid), .i_wready(w_ready), .o_wdata(w_data),
    .o_wstrb(w_strb), .i_bvalid(b_valid), .o_bready(b_ready), .i_bresp(b_resp),
    .o_arvalid(ar_valid), .i_arready(ar_ready), .o_araddr(ar_addr),
    .i_rvalid(r_valid), .o_rready(r_ready));

  // clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // pulse counters and read monitor against the oldest note
  always @(posedge i_clk)
  begin
    n_rst += int'(filt_rst === 1'b1);
    n_st  += int'(start === 1'b1);
    if (r_valid && r_ready)
    begin
      e = exp_q.pop_front();
      `CHK(r_resp, e[33:32])
      if (e[34]) `CHK(r_data, e[31:0])
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic rd_chk(input logic [7:0] a, input bit ck, input logic [1:0] rs,
                        input logic [31:0] d);
    exp_q.push_back({ck, rs, d});
    HOST.rd(a);
  endtask : rd_chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // watchdog
  initial
  begin
    #(25ns * 6000);
    num_errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    {i_sys_rst, chan_sw, conv_dn, single} = 4'h8;
    {num_errors, n_tests, n_rst, n_st} = '0;
    seed = 32'h0001_8553;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    `CHK(analog, 5'b01000)
    rd_chk(amc_pkg::OPCTL_ADDR, 1'b1, amc_pkg::RESP_OKAY, 32'h0000_2000);
    $display("reset test done");
    // every mode with random fields
    for (int m = 0; m < 8; m++)
    begin
      seed = lfsr(seed);
      v = (seed[15:0] & 16'hE70C) | 16'(m << 4);
      single <= seed[16];
      conv_dn <= 1'b1;
      @(posedge i_clk) conv_dn <= 1'b0;
      @(negedge i_clk) `CHK(conv_rdy, 1'b1)
      r0 = n_rst;
      s0 = n_st;
      HOST.wr(amc_pkg::OPCTL_ADDR, {16'h0, v}, 1'b0, resp);
      repeat (2) @(negedge i_clk);
      `CHK(n_rst - r0, 1)
      `CHK(n_st - s0, (m == 2 || m == 3) ? 0 : 1)
      `CHK(conv_rdy, 1'b0)
      `CHK(mode, v[6:4])
      `CHK(analog, {v[15], v[3:2] < 2, v[3:2] == 1, v[3:2] == 2, v[3:2] == 3})
      `CHK(settled, v[13] & single)
      rd_chk(amc_pkg::OPCTL_ADDR, 1'b1, amc_pkg::RESP_OKAY, {16'h0, v});
    end
    $display("mode test done");
    // reserved bits and an unmapped address
    HOST.wr(amc_pkg::OPCTL_ADDR, 32'hFFFF_FFFF, 1'b1, resp);
    rd_chk(amc_pkg::OPCTL_ADDR, 1'b1, amc_pkg::RESP_OKAY, 32'h0000_E77C);
    HOST.wr(8'h10, 32'h0, 1'b0, resp);
    `CHK(resp, amc_pkg::RESP_SLVERR)
    rd_chk(8'h10, 1'b0, amc_pkg::RESP_SLVERR, 32'h0);
    // status write is accepted and ignored; status read shows conversion-ready
    HOST.wr(amc_pkg::STATUS_ADDR, 32'h0, 1'b0, resp);
    `CHK(resp, amc_pkg::RESP_OKAY)
    conv_dn <= 1'b1;
    @(posedge i_clk) conv_dn <= 1'b0;
    rd_chk(amc_pkg::STATUS_ADDR, 1'b1, amc_pkg::RESP_OKAY, 32'h0000_0001);
    $display("reserved test done");
    // settling hold for every delay code
    for (int c = 0; c < 8; c++)
    begin
      HOST.wr(amc_pkg::OPCTL_ADDR, 32'(c << 8), 1'b0, resp);
      @(posedge i_clk) chan_sw <= 1'b1;
      @(posedge i_clk) chan_sw <= 1'b0;
      cnt = 0;
      repeat (20) @(negedge i_clk) cnt += int'(hold === 1'b1);
      `CHK(cnt, N_CYC[c])
    end
    $display("settling test done");
    stop_test();
  end
endmodule : adc_mode_control_tb_top
